/* File: design/rpo_out_select.sv */
// Output function selection for remappable pins 8 to 25, Wishbone slave
//
// Overview of operation
// R01 - Each remappable pin has a 5-bit software selector choosing the peripheral output function that drives it.
// R02 - Each 16-bit register holds the odd pin's selector in bits 12..8 and the even pin's in bits 4..0.
// R03 - Bits 15..13 of every selector register read as zero and ignore writes.
// R04 - Bits 7..5 of every selector register read as zero and ignore writes.
// R05 - Registers for pins 16 to 25 exist only on the 44-pin variant.
// R06 - All selector bits are read-write and clear to zero at reset.
// R07 - Selector zero, or any unlisted function number, connects no peripheral and leaves the pin to the port.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rpo_out_select
  import rpo_pkg::*;
#(
  parameter bit          BIG_PKG  = 1'b1,
  parameter int unsigned NUM_FUNC = 19
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ADDR_W-1:0]        wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          wb_err_o,
  input  wire logic [NUM_FUNC:1]        periph_out_i,
  input  wire logic [17:0]              port_out_i,
  output logic      [17:0]              pin_out_o,
  output logic      [17:0]              pin_remapped_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [15:0] sel_r [NUM_REGS];
  logic        req;
  logic        hit;
  logic [3:0]  idx;
  logic        is_status;

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[5:2];
  endfunction

  // R05 upper registers only on the big package
  function automatic logic reg_present(input logic [3:0] i);
    reg_present = (i < 4'(NUM_REGS)) && (BIG_PKG || (i < 4'(BIG_FIRST)));
  endfunction

  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx       = reg_index(wb_adr_i);
  assign is_status = (wb_adr_i == OFS_STATUS);
  assign hit       = (wb_adr_i[1:0] == 2'b00) && (is_status || reg_present(idx));

  ////////////////////////////////////////////////////////////////////////////
  // Selector registers

  // R02 R03 R04 R06 write path keeps only field bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        sel_r[i] <= SEL_RESET;
      end
    end else if (req && wb_we_i && hit && !is_status) begin
      if (wb_sel_i[0]) begin
        sel_r[idx][7:0] <= wb_dat_i[7:0] & SEL_MASK[7:0];
      end
      if (wb_sel_i[1]) begin
        sel_r[idx][15:8] <= wb_dat_i[15:8] & SEL_MASK[15:8];
      end
    end
  end

  // Ack or error one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      if (req && hit && !wb_we_i) begin
        // R03 R04 reserved bits read zero
        wb_dat_o <= is_status ? {31'h0000_0000, BIG_PKG} : {16'h0000, sel_r[idx] & SEL_MASK};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer

  function automatic logic [FSEL_W-1:0] pin_field(input int unsigned p);
    logic [15:0] r;
    r = sel_r[p/2];
    pin_field = (p % 2 == 1) ? r[ODD_LSB +: FSEL_W] : r[EVEN_LSB +: FSEL_W];
  endfunction

  logic [17:0] mux_val;
  logic [17:0] mux_used;

  // R01 R07 selector steers the pin, zero or unknown falls back to port
  always_comb begin
    logic [FSEL_W-1:0] f;
    f = '0;
    for (int p = 0; p < 18; p++) begin
      f = pin_field(p);
      if (!reg_present(4'(p/2)) || f == '0 || int'(f) > NUM_FUNC) begin
        mux_used[p] = 1'b0;
        mux_val[p]  = port_out_i[p];
      end else begin
        mux_used[p] = 1'b1;
        mux_val[p]  = periph_out_i[f];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o      <= '0;
      pin_remapped_o <= '0;
    end else begin
      pin_out_o      <= mux_val;
      pin_remapped_o <= mux_used;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_RSV_HIGH_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    wb_dat_o[15:13] == 3'b000) else $error("reserved bits 15..13 read nonzero");
  AST_RSV_MID_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    wb_dat_o[7:5] == 3'b000) else $error("reserved bits 7..5 read nonzero");
  AST_WRITE_STORED: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    (req && wb_we_i && hit && !is_status && wb_sel_i[0]) |=> sel_r[$past(idx)][4:0] == $past(wb_dat_i[4:0]))
    else $error("even selector not stored");
  AST_ODD_FIELD: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    (req && wb_we_i && hit && !is_status && wb_sel_i[1]) |=> sel_r[$past(idx)][12:8] == $past(wb_dat_i[12:8]))
    else $error("odd selector not stored");
  AST_SMALL_ABSENT: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    (req && !BIG_PKG && wb_adr_i[5:2] >= 4'(BIG_FIRST) && !is_status) |=> wb_err_o && !wb_ack_o)
    else $error("upper register answered on small package");
  AST_ZERO_PORT: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    (pin_field(0) == '0) |=> pin_out_o[0] == $past(port_out_i[0]) && !pin_remapped_o[0])
    else $error("zero selector did not give pin to port");
  AST_REMAP: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (pin_field(1) == 5'h01) |=> pin_remapped_o[1] && pin_out_o[1] == $past(periph_out_i[1]))
    else $error("pin not driven by selected function");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    (req && hit) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not single cycle");
  AST_RESET_CLEAR: assert property (@(posedge clk_i) // R06
    $past(rst_i) |-> sel_r[0] == SEL_RESET) else $error("selector not cleared by reset");
  AST_ACK_ERR_EXCL: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    !(wb_ack_o && wb_err_o)) else $error("ack and err together");
  AST_DAT_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
  AST_SMALL_UPPER_PORT: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    !BIG_PKG |-> pin_remapped_o[17:8] == 10'h000) else $error("absent selector steered a pin");

  COV_WRITE: cover property (@(posedge clk_i) disable iff (rst_i) req && wb_we_i && hit);
  COV_READ: cover property (@(posedge clk_i) disable iff (rst_i) req && !wb_we_i && hit);
  COV_ERR: cover property (@(posedge clk_i) disable iff (rst_i) wb_err_o);
  COV_REMAP: cover property (@(posedge clk_i) disable iff (rst_i) |pin_remapped_o);

endmodule
`default_nettype wire

/* File: design/rpo_pkg.sv */
// Package for the remappable output pin select block
package rpo_pkg;
  localparam int unsigned FSEL_W       = 5;
  localparam int unsigned ODD_LSB      = 8;
  localparam int unsigned EVEN_LSB     = 0;
  localparam logic [15:0] SEL_RESET    = 16'h0000;
  localparam logic [15:0] SEL_MASK     = 16'h1f1f;
  localparam int unsigned FIRST_PIN    = 8;
  localparam int unsigned NUM_REGS     = 9;
  localparam int unsigned BIG_FIRST    = 4;
  localparam int unsigned ADDR_W       = 6;
  localparam logic [5:0]  OFS_SEL_8_9  = 6'h00;
  localparam logic [5:0]  OFS_SEL_24_25 = 6'h20;
  localparam logic [5:0]  OFS_STATUS   = 6'h24;
endpackage

/* File: verif/rpo_periph_model.sv */
// Model of the peripheral output functions
`timescale 1ns/10ps
`default_nettype none
module rpo_periph_model (
  input  wire logic        clk_i,
  output logic      [19:1] periph_out_o
);
  initial periph_out_o = 19'h2a5a5;
  // Levels move every cycle
  always @(posedge clk_i) begin
    periph_out_o <= {periph_out_o[18:1], ~periph_out_o[19]};
  end
endmodule
`default_nettype wire

/* File: verif/test_rpo_out_select.sv */
// Self-checking bench for the output pin select block
`timescale 1ns/10ps
`default_nettype none
module test_rpo_out_select;
  import rpo_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, wb_ack_o, wb_err_o;
  logic [5:0]  adr = 0;
  logic [31:0] dat = 0, wb_dat_o, x = 32'hf304;
  logic [19:1] periph;
  logic [17:0] port = 0, pin_out_o, pin_remapped_o, exp_pin = 0, exp_rm = 0;
  logic [4:0]  sel_m [18];
  logic [33:0] notes [$];
  logic [33:0] nt;
  logic        small_ack, small_err;
  logic [31:0] small_dat;
  logic [17:0] small_pin, small_rm;
  int          failures = 0, total_checks = 0, i;
  always #2 clk_i = ~clk_i;
  rpo_periph_model u_rpo_periph_model (.clk_i(clk_i), .periph_out_o(periph));
  rpo_out_select u_rpo_out_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h3), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .periph_out_i(periph), .port_out_i(port),
    .pin_out_o(pin_out_o), .pin_remapped_o(pin_remapped_o));
  // Small package variant sharing the bus
  rpo_out_select #(.BIG_PKG(1'b0)) u_rpo_out_select_small (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h3), .wb_dat_o(small_dat),
    .wb_ack_o(small_ack), .wb_err_o(small_err), .periph_out_i(periph), .port_out_i(port),
    .pin_out_o(small_pin), .pin_remapped_o(small_rm));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [33:0] note);
    int n;
    n = 0;
    notes.push_back(note);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    if (n >= 20) begin
      failures++;
      close_out();
    end
    cyc <= 0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) if (wb_ack_o || wb_err_o) begin
    nt = notes.pop_front();
    check("err", {31'h0, wb_err_o}, {31'h0, nt[32]});
    if (nt[33]) check("rdata", wb_dat_o, nt[31:0]);
    check("small err", {31'h0, small_err}, {31'h0, nt[32] | (adr >= 6'h10 && adr <= 6'h20)});
  end
  // Pin mux reference, one cycle behind its inputs
  always @(negedge clk_i) begin
    if (!rst_i) check("pins", {14'h0, pin_out_o}, {14'h0, exp_pin});
    if (!rst_i) check("remap", {14'h0, pin_remapped_o}, {14'h0, exp_rm});
    if (!rst_i) check("small remap", {22'h0, small_rm[17:8]}, 32'h0);
    if (wb_ack_o && we && adr < OFS_STATUS) begin
      sel_m[adr[5:2]*2] = dat[4:0];
      sel_m[adr[5:2]*2+1] = dat[12:8];
    end
    for (int p = 0; p < 18; p++) begin
      exp_rm[p] = sel_m[p] != 0 && sel_m[p] <= 19;
      exp_pin[p] = exp_rm[p] ? periph[sel_m[p]] : port[p];
    end
  end
  initial begin
    foreach (sel_m[p]) sel_m[p] = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (i = 0; i <= 9; i++) bus(0, 6'(4*i), 0, {2'b10, (i == 9) ? 32'h1 : 32'h0});
    $display("reset values done");
    for (i = 0; i < 45; i++) begin
      x = xs(x);
      port <= x[17:0];
      bus(1, 6'(4*(i%9)), x | 32'he0e0, 0);
      bus(0, 6'(4*(i%9)), 0, {2'b10, 16'h0, x[15:0] & SEL_MASK});
    end
    $display("selector traffic done");
    bus(0, 6'h28, 0, {2'b01, 32'h0});
    bus(1, 6'h3c, x, {2'b01, 32'h0});
    $display("unmapped access done");
    repeat (3) @(posedge clk_i);
    close_out();
  end
endmodule
`default_nettype wire
